// File: hw/sfb_bank.sv
// Register bank slave plus port-three pin muxing for crystal and divided clock.
// Assumes strap inputs are quasi-static pins; they are synchronised before use.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
// Summary of operation
// RQ1 - With clock output enabled, pin0 drives the CPU clock divided by two.
// RQ2 - Clock output works only from RC, watchdog or external clock, not crystal timer.
// RQ3 - Crystal configuration turns pin0 into the oscillator amplifier output.
// RQ4 - Pin1 is a port pin only with RC/watchdog clock and no crystal timer.
// RQ5 - Software never touches undefined register addresses.
// RQ6 - Software uses each register only for its intended function.
// RQ7 - Reserved bits are written zero and may read as anything.
// RQ8 - Fixed-zero bits are written zero and read back zero.
// RQ9 - Fixed-one bits are written one and read back one.
// RQ10 - Accumulator and second operand registers are bit addressable.
// RQ11 - Reset loads listed values; data-memory control loads 08.
module sfb_bank
	import sfb_pkg::*;
(
	input  wire logic       clock,
	input  wire logic       sys_rst,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic [7:0] bit_addr,
	input  wire logic       bit_wdata,
	input  wire logic       bit_wr,
	input  wire logic       bit_rd,
	output logic            bit_rdata,
	input  wire logic [1:0] cpu_clk_src,
	input  wire logic       xtal_timer_sel,
	input  wire logic       osc_amp_out,
	input  wire logic       port3_pin0_out,
	input  wire logic       port3_pin0_oe,
	input  wire logic       port3_pin1_out,
	input  wire logic       port3_pin1_oe,
	output logic            port3_pin0_o,
	output logic            port3_pin0_en,
	output logic            port3_pin1_o,
	output logic            port3_pin1_en,
	output logic            clock_output_enable,
	output logic            crystal_input_pin_sel
);
	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	logic [7:0] auxiliary_function_q, cmp1_q, comparator_two_control_q, bctl_q, blo_q, bhi_q;
	logic [7:0] acc_q, ccca_q, cccb_q, cccc_q, cccd_q, sec_q, dmem_q, clkopt_q;
	logic [1:0] src_s1_q, src_s2_q;
	logic       xts_s1_q, xts_s2_q;
	logic       osc_s1_q, osc_s2_q;
	logic       div_q;
	logic       divided_clock_output_ok, xtal_mode, pin1_free;

	wire        bit_acc = bit_addr[7:3] == SFB_BITWIN_ACCUM;
	wire        bit_sec = bit_addr[7:3] == SFB_BITWIN_SECOND;
	wire  [2:0] bit_idx = bit_addr[2:0];

	// ----------------------------------------
	// Strap synchronisers
	// ----------------------------------------
	always_ff @(posedge clock) begin
		src_s1_q <= cpu_clk_src;
		src_s2_q <= src_s1_q;
		xts_s1_q <= xtal_timer_sel;
		xts_s2_q <= xts_s1_q;
		// Amplifier level comes from the analogue side, so it is resynchronised too
		osc_s1_q <= osc_amp_out;
		osc_s2_q <= osc_s1_q;
	end

	// ----------------------------------------
	// Byte-wide registers
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			auxiliary_function_q   <= SFB_RST_ZERO;        // [RQ11]
			cmp1_q   <= SFB_RST_ZERO;
			comparator_two_control_q   <= SFB_RST_ZERO;
			bctl_q   <= SFB_RST_ZERO;
			blo_q    <= SFB_RST_ZERO;
			bhi_q    <= SFB_RST_ZERO;
			ccca_q   <= SFB_RST_ZERO;
			cccb_q   <= SFB_RST_ZERO;
			cccc_q   <= SFB_RST_ZERO;
			cccd_q   <= SFB_RST_ZERO;
			dmem_q   <= SFB_RST_DMEM_CTL;    // [RQ11]
			clkopt_q <= SFB_RST_ZERO;
		end else if (reg_wr) begin
			// Masks keep fixed and reserved bits at their constant value
			unique case (reg_addr)
				SFB_ADDR_AUXILIARY_FUNCTION_FN:  auxiliary_function_q   <= reg_wdata & SFB_MASK_AUXILIARY_FUNCTION;      // [RQ8] [RQ7]
				SFB_ADDR_CMP_ONE:  cmp1_q   <= reg_wdata & SFB_MASK_CMP;       // [RQ7]
				SFB_ADDR_CMP_TWO:  comparator_two_control_q   <= reg_wdata & SFB_MASK_CMP;
				SFB_ADDR_BAUD_CTL: bctl_q   <= reg_wdata & SFB_MASK_BAUD_CTL;
				SFB_ADDR_BAUD_LO:  blo_q    <= reg_wdata;
				SFB_ADDR_BAUD_HI:  bhi_q    <= reg_wdata;
				SFB_ADDR_CCC_A:    ccca_q   <= reg_wdata;
				SFB_ADDR_CCC_B:    cccb_q   <= reg_wdata;
				SFB_ADDR_CCC_C:    cccc_q   <= reg_wdata & SFB_MASK_CCC_CD;
				SFB_ADDR_CCC_D:    cccd_q   <= reg_wdata & SFB_MASK_CCC_CD;
				SFB_ADDR_DMEM_CTL: dmem_q   <= (reg_wdata & SFB_MASK_DMEM) | SFB_ONES_DMEM;  // [RQ9]
				SFB_ADDR_CLK_OPT:  clkopt_q <= reg_wdata & SFB_MASK_CLK_OPT;
				default: ;  // Undefined addresses ignore writes [RQ5]
			endcase
		end
	end

	// ----------------------------------------
	// Bit addressable registers
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			acc_q <= SFB_RST_ZERO;  // [RQ11]
			sec_q <= SFB_RST_ZERO;
		end else if (reg_wr && reg_addr == SFB_ADDR_ACCUM) begin
			acc_q <= reg_wdata;
		end else if (reg_wr && reg_addr == SFB_ADDR_SECOND) begin
			sec_q <= reg_wdata;
		end else if (bit_wr && bit_acc) begin
			acc_q[bit_idx] <= bit_wdata;  // [RQ10]
		end else if (bit_wr && bit_sec) begin
			sec_q[bit_idx] <= bit_wdata;  // [RQ10]
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			reg_rdata <= SFB_RST_ZERO;
		end else if (reg_rd) begin
			unique case (reg_addr)
				SFB_ADDR_AUXILIARY_FUNCTION_FN:  reg_rdata <= auxiliary_function_q;    // Fixed zero bit reads zero [RQ8]
				SFB_ADDR_CMP_ONE:  reg_rdata <= cmp1_q;
				SFB_ADDR_CMP_TWO:  reg_rdata <= comparator_two_control_q;
				SFB_ADDR_BAUD_CTL: reg_rdata <= bctl_q;
				SFB_ADDR_BAUD_LO:  reg_rdata <= blo_q;
				SFB_ADDR_BAUD_HI:  reg_rdata <= bhi_q;
				SFB_ADDR_ACCUM:    reg_rdata <= acc_q;
				SFB_ADDR_CCC_A:    reg_rdata <= ccca_q;
				SFB_ADDR_CCC_B:    reg_rdata <= cccb_q;
				SFB_ADDR_CCC_C:    reg_rdata <= cccc_q;
				SFB_ADDR_CCC_D:    reg_rdata <= cccd_q;
				SFB_ADDR_SECOND:   reg_rdata <= sec_q;
				SFB_ADDR_DMEM_CTL: reg_rdata <= dmem_q;    // Fixed one bit reads one [RQ9]
				SFB_ADDR_CLK_OPT:  reg_rdata <= clkopt_q;
				default:           reg_rdata <= SFB_RST_ZERO;  // [RQ5]
			endcase
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			bit_rdata <= 1'b0;
		end else if (bit_rd) begin
			bit_rdata <= bit_acc ? acc_q[bit_idx] : (bit_sec ? sec_q[bit_idx] : 1'b0);  // [RQ10]
		end
	end

	// ----------------------------------------
	// Clock pin options
	// ----------------------------------------
	assign xtal_mode = src_s2_q == SFB_SRC_XTAL;  // [RQ3]
	assign divided_clock_output_ok = !xtal_mode && !xts_s2_q;  // [RQ2]
	assign pin1_free = (src_s2_q == SFB_SRC_RC || src_s2_q == SFB_SRC_WDOG) && !xts_s2_q;  // [RQ4]

	// Toggle each CPU clock gives clock divided by two; held low when unused to save power
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			div_q <= 1'b0;
		end else if (clkopt_q[SFB_BIT_CLK_EN] && divided_clock_output_ok) begin
			div_q <= !div_q;  // [RQ1]
		end else begin
			div_q <= 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			port3_pin0_o          <= 1'b0;
			port3_pin0_en         <= 1'b0;
			port3_pin1_o          <= 1'b0;
			port3_pin1_en         <= 1'b0;
			clock_output_enable   <= 1'b0;
			crystal_input_pin_sel <= 1'b0;
		end else begin
			// Oscillator output takes priority over clock output and port use
			if (xtal_mode) begin
				port3_pin0_o  <= osc_s2_q;  // [RQ3]
				port3_pin0_en <= 1'b1;
			end else if (clkopt_q[SFB_BIT_CLK_EN] && divided_clock_output_ok) begin
				port3_pin0_o  <= div_q;  // [RQ1] [RQ2]
				port3_pin0_en <= 1'b1;
			end else begin
				port3_pin0_o  <= port3_pin0_out;
				port3_pin0_en <= port3_pin0_oe;
			end
			port3_pin1_o          <= pin1_free ? port3_pin1_out : 1'b0;  // [RQ4]
			port3_pin1_en         <= pin1_free && port3_pin1_oe;
			clock_output_enable   <= clkopt_q[SFB_BIT_CLK_EN] && divided_clock_output_ok;
			crystal_input_pin_sel <= !pin1_free;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_clk_enabled;
		clkopt_q[SFB_BIT_CLK_EN] && divided_clock_output_ok && !xtal_mode;
	endsequence

	a_divided_clock_output_toggles: assert property (@(posedge clock) disable iff (sys_rst)
		s_clk_enabled ##1 s_clk_enabled |-> ##1 (port3_pin0_o != $past(port3_pin0_o)))  // [RQ1]
		else $error("clock output did not toggle");
	a_divided_clock_output_blocked: assert property (@(posedge clock) disable iff (sys_rst)
		xts_s2_q |=> !clock_output_enable)  // [RQ2]
		else $error("clock output active with crystal timer");
	a_xtal_pin_drive: assert property (@(posedge clock) disable iff (sys_rst)
		xtal_mode |=> port3_pin0_en && port3_pin0_o == $past(osc_s2_q))  // [RQ3]
		else $error("pin0 not oscillator output");
	a_pin1_gated: assert property (@(posedge clock) disable iff (sys_rst)
		!pin1_free |=> !port3_pin1_en)  // [RQ4]
		else $error("pin1 driven while reserved for crystal");
	a_zero_bit_read: assert property (@(posedge clock) disable iff (sys_rst)
		reg_rd && reg_addr == SFB_ADDR_AUXILIARY_FUNCTION_FN |=> reg_rdata[SFB_BIT_AUXILIARY_FUNCTION_ZERO] == 1'b0)  // [RQ8]
		else $error("fixed zero bit read as one");
	a_one_bit_read: assert property (@(posedge clock) disable iff (sys_rst)
		reg_rd && reg_addr == SFB_ADDR_DMEM_CTL |=> reg_rdata[SFB_BIT_DMEM_ONE] == 1'b1)  // [RQ9]
		else $error("fixed one bit read as zero");
	a_bit_write_acc: assert property (@(posedge clock) disable iff (sys_rst)
		bit_wr && bit_acc && !reg_wr |=> acc_q[$past(bit_idx)] == $past(bit_wdata))  // [RQ10]
		else $error("accumulator bit write lost");
	a_reset_values: assert property (@(posedge clock)
		sys_rst |=> dmem_q == SFB_RST_DMEM_CTL && acc_q == SFB_RST_ZERO && auxiliary_function_q == SFB_RST_ZERO)  // [RQ11]
		else $error("reset value wrong");
	a_undef_reads: assert property (@(posedge clock) disable iff (sys_rst)
		reg_rd && reg_addr == SFB_ADDR_UNUSED |=> reg_rdata == SFB_RST_ZERO)  // [RQ5]
		else $error("undefined address read nonzero");
	a_reserved_clear: assert property (@(posedge clock) disable iff (sys_rst)
		reg_wr && reg_addr == SFB_ADDR_BAUD_CTL |=> (bctl_q & ~SFB_MASK_BAUD_CTL) == SFB_RST_ZERO)  // [RQ7]
		else $error("reserved baud control bits stored");

	// ----------------------------------------
	// Checks on masked register storage
	// ----------------------------------------
	// Stored zeros make reserved bits read a stable value, a stricter choice than required
	a_auxiliary_function_masked: assert property (@(posedge clock) disable iff (sys_rst)
		reg_wr && reg_addr == SFB_ADDR_AUXILIARY_FUNCTION_FN |=> (auxiliary_function_q & ~SFB_MASK_AUXILIARY_FUNCTION) == SFB_RST_ZERO)  // [RQ7]
		else $error("auxiliary reserved bits stored");
	a_cmp_one_masked: assert property (@(posedge clock) disable iff (sys_rst)
		reg_wr && reg_addr == SFB_ADDR_CMP_ONE |=> (cmp1_q & ~SFB_MASK_CMP) == SFB_RST_ZERO)  // [RQ7]
		else $error("comparator one reserved bits stored");
	a_cmp_two_masked: assert property (@(posedge clock) disable iff (sys_rst)
		reg_wr && reg_addr == SFB_ADDR_CMP_TWO |=> (comparator_two_control_q & ~SFB_MASK_CMP) == SFB_RST_ZERO)  // [RQ7]
		else $error("comparator two reserved bits stored");
	a_ccc_c_masked: assert property (@(posedge clock) disable iff (sys_rst)
		reg_wr && reg_addr == SFB_ADDR_CCC_C |=> (cccc_q & ~SFB_MASK_CCC_CD) == SFB_RST_ZERO)  // [RQ7]
		else $error("capture compare c reserved bits stored");
	a_ccc_d_masked: assert property (@(posedge clock) disable iff (sys_rst)
		reg_wr && reg_addr == SFB_ADDR_CCC_D |=> (cccd_q & ~SFB_MASK_CCC_CD) == SFB_RST_ZERO)  // [RQ7]
		else $error("capture compare d reserved bits stored");
	a_dmem_one_held: assert property (@(posedge clock) disable iff (sys_rst)
		(dmem_q & SFB_ONES_DMEM) == SFB_ONES_DMEM)  // [RQ9]
		else $error("data memory fixed one bit lost");
	a_clkopt_masked: assert property (@(posedge clock) disable iff (sys_rst)
		reg_wr && reg_addr == SFB_ADDR_CLK_OPT |=> (clkopt_q & ~SFB_MASK_CLK_OPT) == SFB_RST_ZERO)  // [RQ7]
		else $error("clock option reserved bits stored");

	// ----------------------------------------
	// Checks on bit access and read data
	// ----------------------------------------
	sequence s_acc_byte_write;
		reg_wr && reg_addr == SFB_ADDR_ACCUM;
	endsequence

	a_byte_beats_bit: assert property (@(posedge clock) disable iff (sys_rst)
		s_acc_byte_write |=> acc_q == $past(reg_wdata))  // [RQ10]
		else $error("accumulator byte write lost");
	a_bit_write_sec: assert property (@(posedge clock) disable iff (sys_rst)
		bit_wr && bit_sec && !reg_wr |=> sec_q[$past(bit_idx)] == $past(bit_wdata))  // [RQ10]
		else $error("second operand bit write lost");
	a_bit_read_acc: assert property (@(posedge clock) disable iff (sys_rst)
		bit_rd && bit_acc |=> bit_rdata == $past(acc_q[bit_idx]))  // [RQ10]
		else $error("accumulator bit read wrong");
	a_bit_read_sec: assert property (@(posedge clock) disable iff (sys_rst)
		bit_rd && bit_sec |=> bit_rdata == $past(sec_q[bit_idx]))  // [RQ10]
		else $error("second operand bit read wrong");
	a_bit_read_other: assert property (@(posedge clock) disable iff (sys_rst)
		bit_rd && !bit_acc && !bit_sec |=> !bit_rdata)  // [RQ5]
		else $error("bit read outside windows nonzero");
	a_baud_lo_read: assert property (@(posedge clock) disable iff (sys_rst)
		reg_rd && reg_addr == SFB_ADDR_BAUD_LO |=> reg_rdata == $past(blo_q))  // [RQ6]
		else $error("baud low read wrong");

	// ----------------------------------------
	// Checks on reset and pin options
	// ----------------------------------------
	a_reset_outputs: assert property (@(posedge clock)
		sys_rst |=> !port3_pin0_en && !port3_pin1_en && !clock_output_enable)  // [RQ11]
		else $error("pin outputs active after reset");
	a_reset_ccc: assert property (@(posedge clock)
		sys_rst |=> ccca_q == SFB_RST_ZERO && cccd_q == SFB_RST_ZERO && blo_q == SFB_RST_ZERO)  // [RQ11]
		else $error("control reset value wrong");
	a_div_held_low: assert property (@(posedge clock) disable iff (sys_rst)
		!(clkopt_q[SFB_BIT_CLK_EN] && divided_clock_output_ok) |=> !div_q)  // [RQ1]
		else $error("divider running while disabled");
	a_divided_clock_output_flag: assert property (@(posedge clock) disable iff (sys_rst)
		s_clk_enabled |=> clock_output_enable)  // [RQ1]
		else $error("clock output flag missing");
	a_xtal_no_divided_clock_output: assert property (@(posedge clock) disable iff (sys_rst)
		xtal_mode |=> !clock_output_enable)  // [RQ2]
		else $error("clock output active in crystal mode");
	a_pin1_port: assert property (@(posedge clock) disable iff (sys_rst)
		pin1_free |=> port3_pin1_en == $past(port3_pin1_oe) && port3_pin1_o == $past(port3_pin1_out))  // [RQ4]
		else $error("pin1 port drive wrong");
	a_pin1_select: assert property (@(posedge clock) disable iff (sys_rst)
		pin1_free |=> !crystal_input_pin_sel)  // [RQ4]
		else $error("pin1 reserved while free");
	a_pin0_port: assert property (@(posedge clock) disable iff (sys_rst)
		!xtal_mode && !clkopt_q[SFB_BIT_CLK_EN] |=> port3_pin0_en == $past(port3_pin0_oe))  // [RQ3]
		else $error("pin0 port drive wrong");
endmodule : sfb_bank

// File: hw/sfb_pkg.sv
// Package for the special function register bank and port-three clock pin options.
// Assumes one CPU clock domain and a byte-wide register port with 8-bit addresses.
package sfb_pkg;
	// ----------------------------------------
	// Register addresses
	// ----------------------------------------
	localparam logic [7:0] SFB_ADDR_AUXILIARY_FUNCTION_FN   = 8'hA2;
	localparam logic [7:0] SFB_ADDR_CMP_ONE   = 8'hAC;
	localparam logic [7:0] SFB_ADDR_CMP_TWO   = 8'hAD;
	localparam logic [7:0] SFB_ADDR_BAUD_CTL  = 8'hBD;
	localparam logic [7:0] SFB_ADDR_BAUD_LO   = 8'hBE;
	localparam logic [7:0] SFB_ADDR_BAUD_HI   = 8'hBF;
	localparam logic [7:0] SFB_ADDR_ACCUM     = 8'hE0;
	localparam logic [7:0] SFB_ADDR_CCC_A     = 8'hEA;
	localparam logic [7:0] SFB_ADDR_CCC_B     = 8'hEB;
	localparam logic [7:0] SFB_ADDR_CCC_C     = 8'hEC;
	localparam logic [7:0] SFB_ADDR_CCC_D     = 8'hED;
	localparam logic [7:0] SFB_ADDR_SECOND    = 8'hF0;
	localparam logic [7:0] SFB_ADDR_DMEM_CTL  = 8'hF1;
	localparam logic [7:0] SFB_ADDR_CLK_OPT   = 8'hC0;
	// Bit-address windows of the bit addressable registers
	localparam logic [4:0] SFB_BITWIN_ACCUM   = 5'h1C;
	localparam logic [4:0] SFB_BITWIN_SECOND  = 5'h1E;
	// ----------------------------------------
	// Reset values and writable masks
	// ----------------------------------------
	localparam logic [7:0] SFB_RST_ZERO       = 8'h00;
	localparam logic [7:0] SFB_RST_DMEM_CTL   = 8'h08;
	localparam logic [7:0] SFB_MASK_AUXILIARY_FUNCTION      = 8'hF9;
	localparam logic [7:0] SFB_MASK_CMP       = 8'h3F;
	localparam logic [7:0] SFB_MASK_BAUD_CTL  = 8'h03;
	localparam logic [7:0] SFB_MASK_CCC_CD    = 8'h07;
	localparam logic [7:0] SFB_MASK_DMEM      = 8'hF7;
	localparam logic [7:0] SFB_ONES_DMEM      = 8'h08;
	localparam logic [7:0] SFB_MASK_CLK_OPT   = 8'h01;
	localparam int         SFB_BIT_CLK_EN     = 0;
	localparam int         SFB_BIT_AUXILIARY_FUNCTION_ZERO  = 2;
	localparam int         SFB_BIT_DMEM_ONE   = 3;
	// One address the map leaves undefined, used by the checks
	localparam logic [7:0] SFB_ADDR_UNUSED    = 8'h00;
	// ----------------------------------------
	// Clock source codes
	// ----------------------------------------
	localparam logic [1:0] SFB_SRC_RC         = 2'h0;
	localparam logic [1:0] SFB_SRC_WDOG       = 2'h1;
	localparam logic [1:0] SFB_SRC_EXT        = 2'h2;
	localparam logic [1:0] SFB_SRC_XTAL       = 2'h3;
endpackage : sfb_pkg

// File: test/tb_sfb_bank.sv
// Self-checking bench for the register bank and port-three clock pin options.
// Assumes the design files under hw/ are compiled first; the bench drives every port itself.
`timescale 1ns/1ps
module tb_sfb_bank
	import sfb_pkg::*;
;
	// ----------------------------------------
	// Stimulus signals and tables
	// ----------------------------------------
	logic       clock, sys_rst, reg_wr, reg_rd, bit_wdata, bit_wr, bit_rd, bit_rdata;
	logic       xtal_timer_sel, osc_amp_out, port3_pin0_out, port3_pin0_oe, port3_pin1_out, port3_pin1_oe;
	logic       port3_pin0_o, port3_pin0_en, port3_pin1_o, port3_pin1_en;
	logic       clock_output_enable, crystal_input_pin_sel;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, bit_addr;
	logic [1:0] cpu_clk_src;
	int         n_errors, n_tests, cycles;
	localparam logic [7:0] ADDRS [13] = '{SFB_ADDR_AUXILIARY_FUNCTION_FN, SFB_ADDR_CMP_ONE, SFB_ADDR_CMP_TWO, SFB_ADDR_BAUD_CTL,
		SFB_ADDR_BAUD_LO, SFB_ADDR_BAUD_HI, SFB_ADDR_ACCUM, SFB_ADDR_CCC_A, SFB_ADDR_CCC_B, SFB_ADDR_CCC_C,
		SFB_ADDR_CCC_D, SFB_ADDR_SECOND, SFB_ADDR_DMEM_CTL};
	// Read-back after writing all ones: reserved and fixed bits masked
	localparam logic [7:0] ONES [13] = '{SFB_MASK_AUXILIARY_FUNCTION, SFB_MASK_CMP, SFB_MASK_CMP, SFB_MASK_BAUD_CTL, 8'hFF, 8'hFF,
		8'hFF, 8'hFF, 8'hFF, SFB_MASK_CCC_CD, SFB_MASK_CCC_CD, 8'hFF, SFB_MASK_DMEM | SFB_ONES_DMEM};

	sfb_bank sfb_bank_inst (.clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bit_addr,
		.bit_wdata, .bit_wr, .bit_rd, .bit_rdata, .cpu_clk_src, .xtal_timer_sel, .osc_amp_out, .port3_pin0_out,
		.port3_pin0_oe, .port3_pin1_out, .port3_pin1_oe, .port3_pin0_o, .port3_pin0_en, .port3_pin1_o,
		.port3_pin1_en, .clock_output_enable, .crystal_input_pin_sel);

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// Generous ceiling: the whole run needs well under a thousand cycles
	always @(posedge clock) begin
		cycles++;
		if (cycles == 4000) begin
			n_errors++;
			test_done();
		end
	end
	// ----------------------------------------
	// Bus and compare tasks
	// ----------------------------------------
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk8
	task automatic chk1(input string what, input logic exp, input logic got);
		chk8(what, {7'h00, exp}, {7'h00, got});
	endtask : chk1
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr    <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd   <= 1'b0;
		#1 chk8($sformatf("register %h", a), exp, reg_rdata);
	endtask : rd
	task automatic bit_access(input logic [7:0] a, input logic wr_en, input logic d);
		@(posedge clock);
		bit_addr  <= a;
		bit_wdata <= d;
		bit_wr    <= wr_en;
		bit_rd    <= !wr_en;
		@(posedge clock);
		bit_wr    <= 1'b0;
		bit_rd    <= 1'b0;
		#1 if (!wr_en) chk1($sformatf("bit %h", a), d, bit_rdata);
	endtask : bit_access
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		for (int k = 0; k < 13; k++) rd(ADDRS[k], (k == 12) ? SFB_RST_DMEM_CTL : SFB_RST_ZERO);
	endtask : t_reset
	task automatic t_masks();
		for (int k = 0; k < 13; k++) wr(ADDRS[k], 8'hFF);
		for (int k = 0; k < 13; k++) rd(ADDRS[k], ONES[k]);
		wr(SFB_ADDR_DMEM_CTL, 8'h00);
		rd(SFB_ADDR_DMEM_CTL, SFB_ONES_DMEM);
		wr(8'hA3, 8'hFF);
		rd(8'hA3, 8'h00);
		rd(SFB_ADDR_UNUSED, SFB_RST_ZERO);
	endtask : t_masks
	task automatic t_bits();
		wr(SFB_ADDR_ACCUM, 8'h00);
		wr(SFB_ADDR_SECOND, 8'h00);
		bit_access(8'hE3, 1'b1, 1'b1);
		bit_access(8'hF7, 1'b1, 1'b1);
		rd(SFB_ADDR_ACCUM, 8'h08);
		rd(SFB_ADDR_SECOND, 8'h80);
		bit_access(8'hE3, 1'b0, 1'b1);
		bit_access(8'hE4, 1'b0, 1'b0);
		bit_access(8'hF7, 1'b0, 1'b1);
	endtask : t_bits
	task automatic t_divided_clock_output();
		logic v, ce, fr, xt;
		wr(SFB_ADDR_CLK_OPT, 8'h01);
		for (int i = 0; i < 8; i++) begin
			@(posedge clock);
			cpu_clk_src    <= i[1:0];
			xtal_timer_sel <= i[2];
			repeat (5) @(posedge clock);
			#1 xt = (i[1:0] == SFB_SRC_XTAL);
			ce = !xt && !i[2];
			fr = (i[1:0] == SFB_SRC_RC || i[1:0] == SFB_SRC_WDOG) && !i[2];
			chk1("clock out enable", ce, clock_output_enable);
			chk1("pin1 crystal select", !fr, crystal_input_pin_sel);
			chk1("pin1 enable", fr, port3_pin1_en);
			if (fr) chk1("pin1 level", port3_pin1_out, port3_pin1_o);
			chk1("pin0 enable", ce || xt, port3_pin0_en);
			if (xt) chk1("pin0 amplifier", osc_amp_out, port3_pin0_o);
			// Divide by two: the level flips at every edge
			for (int n = 0; n < 2 && ce; n++) begin
				v = port3_pin0_o;
				@(posedge clock);
				#1 chk1("pin0 divided clock", !v, port3_pin0_o);
			end
		end
		@(posedge clock);
		cpu_clk_src    <= SFB_SRC_RC;
		xtal_timer_sel <= 1'b0;
		repeat (5) @(posedge clock);
		#1 chk1("clock out on", 1'b1, clock_output_enable);
		wr(SFB_ADDR_CLK_OPT, 8'h00);
		repeat (3) @(posedge clock);
		#1 chk1("clock out off", 1'b0, clock_output_enable);
		chk1("pin0 back to port", port3_pin0_oe, port3_pin0_en);
	endtask : t_divided_clock_output
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{sys_rst, reg_addr, reg_wdata, reg_wr, reg_rd, bit_addr, bit_wdata, bit_wr, bit_rd} = {1'b1, 29'h0};
		{cpu_clk_src, xtal_timer_sel, osc_amp_out} = {SFB_SRC_XTAL, 1'b0, 1'b1};
		{port3_pin0_out, port3_pin0_oe, port3_pin1_out, port3_pin1_oe} = 4'hB;
		repeat (5) @(posedge clock);
		sys_rst <= 1'b0;
		t_reset();
		t_masks();
		@(posedge clock);
		sys_rst <= 1'b1;
		@(posedge clock);
		sys_rst <= 1'b0;
		t_reset();
		t_bits();
		t_divided_clock_output();
		test_done();
	end
endmodule : tb_sfb_bank
